//--- tacm_cfg.svh
// Constant definitions for the two antenna correlator block
`ifndef TACM_CFG_SVH
`define TACM_CFG_SVH

// System clock rate and conversion from nanoseconds to cycles
`define TACM_CLK_MHZ 250
`define TACM_CYC(ns) (((ns) * `TACM_CLK_MHZ) / 1000)
`define TACM_CYC_UP(ns) ((((ns) * `TACM_CLK_MHZ) + 999) / 1000)

// Sample period for the fast and slow rate options
`define TACM_PER_FAST_NS 5120
`define TACM_PER_SLOW_NS 40960
`define TACM_PER_W 14

// Sample pulse width and converter clock timing
`define TACM_SP_NS 200
`define TACM_CONV_MAX_NS 50
`define TACM_CONV_DLY_NS 20
`define TACM_CONV_HALF_NS 32
`define TACM_CONV_PULSES 17

// Word sizes
`define TACM_SER_W 16
`define TACM_OP_W 14
`define TACM_ACC_W 48
`define TACM_BUS_W 16
`define TACM_PROD_DROP 4
`define TACM_NPROD 6
`define TACM_STAGES 5
`define TACM_STAGE_W 4

// Register byte offsets
`define TACM_A_CTRL 8'h00
`define TACM_A_LEN_LO 8'h04
`define TACM_A_LEN_HI 8'h08
`define TACM_A_RSEL 8'h0C
`define TACM_A_ATTEN 8'h10
`define TACM_A_RESULT 8'h14
`define TACM_A_STATUS 8'h18

// Register bit fields
`define TACM_B_START 0
`define TACM_B_SLOW 1
`define TACM_B_RDEN 2
`define TACM_B_REQ 3
`define TACM_B_LDREF 13
`define TACM_B_LDTEST 14
`define TACM_B_BUSY 0
`define TACM_B_ACK 1

// Channel numbers
`define TACM_CH_REF 2'h0
`define TACM_CH_TEST 2'h1
`define TACM_CH_QUAD 2'h2

`endif

//--- tacm_pkg.sv
// Types shared by the correlator files
package tacm_pkg;

  // Control bits written by software
  typedef struct packed {
    logic req;
    logic rden;
    logic slow;
  } tacm_ctrl_type;

  // Readout selection: product and byte
  typedef struct packed {
    logic [2:0] byte_sel;
    logic [2:0] prod;
  } tacm_rsel_type;

  // Multiply-accumulate sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MAC = 2'b10
  } tacm_state_type;

endpackage

//--- tacm_s2p.sv
// Serial to parallel receiver for one sampling converter
`timescale 1ns/1ps
`include "tacm_cfg.svh"

module tacm_s2p #(
  parameter int DW = `TACM_SER_W,
  parameter int OW = `TACM_OP_W,
  parameter int NP = `TACM_CONV_PULSES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw link pins from the converter
  input wire logic ser_clk,
  input wire logic ser_dat,
  // Control from the timing logic
  input wire logic burst_start,
  input wire logic inhibit,
  // Parallel word
  output logic [OW-1:0] word_q,
  output logic word_v_q
);

  logic clk_s1_q, clk_s2_q, clk_s3_q; // Clock synchroniser and edge stage
  logic dat_s1_q, dat_s2_q; // Data synchroniser, same depth as clock
  logic [DW-1:0] sh_q; // Shift register
  logic [4:0] cnt_q; // Clock pulses seen in this burst
  logic rise; // Rising edge of the link clock

  // Two flops on each pin before anything reads them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= 1'b0;
      dat_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= ser_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= ser_dat;
      dat_s2_q <= dat_s1_q;
    end
  end

  assign rise = clk_s2_q & ~clk_s3_q;

  // Shift on each pulse; the first of the burst carries no bit, which
  // lines the clock up with the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_q <= '0;
      cnt_q <= '0;
      word_q <= '0;
      word_v_q <= 1'b0;
    end else if (inhibit) begin
      // Cleared at integration start so the first sample adds nothing
      sh_q <= '0;
      cnt_q <= '0;
      word_q <= '0;
      word_v_q <= 1'b0;
    end else begin
      word_v_q <= 1'b0;
      if (burst_start) begin
        cnt_q <= '0;
      end else if (rise) begin
        // Pulses beyond the burst length are ignored
        if (cnt_q < 5'(NP)) begin
          cnt_q <= cnt_q + 5'h01;
        end
        if (cnt_q != 5'h00 && cnt_q < 5'(NP)) begin
          sh_q <= {sh_q[DW-2:0], dat_s2_q};
        end
        if (cnt_q == 5'(NP - 1)) begin
          // MSB first; the two noise LSBs are dropped
          word_q <= sh_q[DW-2:DW-OW-1];
          word_v_q <= 1'b1;
        end
      end
    end
  end

endmodule

//--- tacm_core.sv
// Three channel correlator: timing, receivers, multiply-accumulate, AHB-Lite registers
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "tacm_cfg.svh"

module tacm_core #(
  parameter int PER_FAST = `TACM_CYC(`TACM_PER_FAST_NS),
  parameter int PER_SLOW = `TACM_CYC(`TACM_PER_SLOW_NS),
  parameter int NCH = 3
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter pins, index 0 ref, 1 test, 2 quad
  input wire logic [NCH-1:0] adc_dclk,
  input wire logic [NCH-1:0] adc_data,
  output logic sample_pulse,
  output logic conv_clk,
  // External start pin
  input wire logic start_pin,
  // Results and settings
  output logic [7:0] result_byte,
  output logic [4:0] ref_atten,
  output logic [4:0] test_atten,
  output logic integrating,
  output logic host_ack
);

  // Timing counts derived from the nanosecond figures
  localparam int SP_CYC = `TACM_CYC_UP(`TACM_SP_NS);
  localparam int DLY_CYC = `TACM_CYC(`TACM_CONV_DLY_NS);
  localparam int DLY_MAX = `TACM_CYC(`TACM_CONV_MAX_NS);
  localparam int HALF_CYC = `TACM_CYC_UP(`TACM_CONV_HALF_NS);
  localparam int BURST_AT = SP_CYC - 1 + ((DLY_CYC < DLY_MAX) ? DLY_CYC : DLY_MAX);
  localparam int CW = `TACM_STAGES * `TACM_STAGE_W;
  localparam int PW = `TACM_SER_W + `TACM_BUS_W;

  // Bus state
  logic wr_q; // Write data phase pending
  logic rd_q; // Read wait cycle pending
  logic [7:0] ap_addr_q; // Captured byte offset
  logic take; // Address phase accepted
  logic [31:0] rd_val; // Read mux

  // Software registers
  tacm_pkg::tacm_ctrl_type ctrl_q; // Rate, read enable, device request
  tacm_pkg::tacm_rsel_type rsel_q; // Readout selection
  logic [7:0] len_lo_q, len_hi_q; // Integration length holding bytes
  logic start_sw_q; // Software start, one cycle

  // Timing
  logic [`TACM_PER_W-1:0] per_cnt_q; // Position in sample period
  logic [`TACM_PER_W-1:0] per_len; // Period length for current rate
  logic tick; // Last cycle of a sample period
  logic [3:0] half_q; // Converter clock half period counter
  logic [5:0] edges_q; // Converter clock toggles left
  logic burst_q; // Burst begins, to the receivers
  logic st_s1_q, st_s2_q, st_s3_q; // Start pin synchroniser
  logic start; // Start request from pin or software

  // Integration
  logic run_q; // Integration counter running
  logic first_q; // First sample period of an integration
  logic [CW-1:0] cnt_q; // Cascaded integration counter
  logic [CW-1:0] cnt_n; // Counter plus one

  // Datapath
  logic [`TACM_OP_W-1:0] word [NCH]; // Receiver words
  logic [`TACM_OP_W-1:0] op_q [NCH]; // Latched sample set
  logic signed [`TACM_ACC_W-1:0] acc_q [`TACM_NPROD]; // Six sums
  tacm_pkg::tacm_state_type st_q; // Sequencer state
  logic [2:0] step_q; // Storage location being updated
  logic signed [`TACM_BUS_W-1:0] xbus, ybus; // Multiplier buses
  logic signed [PW-1:0] prod; // Full product
  logic busy; // Integrating or still accumulating

  // Output registers
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic sp_q, cclk_q, int_q, ack_q;
  logic [7:0] out_q;
  logic [4:0] ref_q, test_q;

  // Channel feeding the multiplier at a step; second picks the Y side
  function automatic logic [1:0] pair_ch(input logic [2:0] s, input logic second);
    case (s)
      3'h0: pair_ch = `TACM_CH_TEST;
      3'h1: pair_ch = `TACM_CH_QUAD;
      3'h2: pair_ch = `TACM_CH_REF;
      3'h3: pair_ch = second ? `TACM_CH_QUAD : `TACM_CH_TEST;
      3'h4: pair_ch = second ? `TACM_CH_REF : `TACM_CH_TEST;
      3'h5: pair_ch = second ? `TACM_CH_REF : `TACM_CH_QUAD;
      default: pair_ch = `TACM_CH_REF;
    endcase
  endfunction

  // Place a 14-bit operand on a 16-bit bus, low bits held zero; an
  // unselected channel contributes zero since the mux has no float state
  function automatic logic [`TACM_BUS_W-1:0] bus_of(input logic [`TACM_OP_W-1:0] o);
    bus_of = {o, {(`TACM_BUS_W - `TACM_OP_W){1'b0}}};
  endfunction

  // Three receivers, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_rx
      tacm_s2p u_rx (
        .hclk(hclk),
        .hresetn(hresetn),
        .ser_clk(adc_dclk[gi]),
        .ser_dat(adc_data[gi]),
        .burst_start(burst_q),
        .inhibit(first_q),
        .word_q(word[gi]),
        .word_v_q()
      );
    end
  endgenerate

  // Bus address phase is taken only with hready high
  assign take = hsel & hready & htrans[1];

  // Bus phase tracking; reads get one wait so they see the last write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      if (take) begin
        ap_addr_q <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        hreadyout_q <= 1'b0;
      end else if (rd_q) begin
        hreadyout_q <= 1'b1;
        hrdata_q <= rd_val;
      end
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (ap_addr_q)
      `TACM_A_CTRL: begin
        rd_val[`TACM_B_SLOW] = ctrl_q.slow;
        rd_val[`TACM_B_RDEN] = ctrl_q.rden;
        rd_val[`TACM_B_REQ] = ctrl_q.req;
      end
      `TACM_A_LEN_LO: rd_val[15:8] = len_lo_q;
      `TACM_A_LEN_HI: rd_val[15:8] = len_hi_q;
      `TACM_A_RSEL: rd_val[6:0] = {rsel_q.byte_sel, 1'b0, rsel_q.prod};
      `TACM_A_ATTEN: rd_val[12:0] = {test_q, 3'h0, ref_q};
      // Read data on the low byte only while the request is up
      `TACM_A_RESULT: rd_val[7:0] = ctrl_q.req ? out_q : 8'h00;
      `TACM_A_STATUS: begin
        rd_val[`TACM_B_BUSY] = int_q;
        rd_val[`TACM_B_ACK] = ack_q;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Control register and software start pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '0;
      start_sw_q <= 1'b0;
    end else begin
      start_sw_q <= 1'b0;
      if (wr_q && ap_addr_q == `TACM_A_CTRL) begin
        ctrl_q.slow <= hwdata[`TACM_B_SLOW];
        ctrl_q.rden <= hwdata[`TACM_B_RDEN];
        ctrl_q.req <= hwdata[`TACM_B_REQ];
        start_sw_q <= hwdata[`TACM_B_START];
      end
    end
  end

  // Length and attenuator registers take the high byte, readout selection the low byte, only while the request is up
  // length kept for every later run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_lo_q <= 8'h00;
      len_hi_q <= 8'h00;
      rsel_q <= '0;
      ref_q <= 5'h00;
      test_q <= 5'h00;
    end else if (wr_q && ctrl_q.req) begin
      case (ap_addr_q)
        `TACM_A_LEN_LO: len_lo_q <= hwdata[15:8];
        `TACM_A_LEN_HI: len_hi_q <= hwdata[15:8];
        `TACM_A_RSEL: begin
          rsel_q.prod <= hwdata[2:0];
          rsel_q.byte_sel <= hwdata[6:4];
        end
        `TACM_A_ATTEN: begin
          // Five shared bits, one load enable each
          if (hwdata[`TACM_B_LDREF]) begin
            ref_q <= hwdata[12:8];
          end
          if (hwdata[`TACM_B_LDTEST]) begin
            test_q <= hwdata[12:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Sample period from the rate option
  assign per_len = ctrl_q.slow ? `TACM_PER_W'(PER_SLOW) : `TACM_PER_W'(PER_FAST);
  assign tick = (per_cnt_q >= per_len - `TACM_PER_W'(1));

  // Free running period counter and sample pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_q <= '0;
      sp_q <= 1'b1;
    end else begin
      per_cnt_q <= tick ? '0 : per_cnt_q + `TACM_PER_W'(1);
      sp_q <= tick || (per_cnt_q < `TACM_PER_W'(SP_CYC - 1));
    end
  end

  // Converter clock burst, first rise a few cycles after the sample
  // pulse falls the delay is capped at the deadline
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cclk_q <= 1'b0;
      half_q <= 4'h0;
      edges_q <= 6'h00;
      burst_q <= 1'b0;
    end else begin
      burst_q <= 1'b0;
      if (per_cnt_q == `TACM_PER_W'(BURST_AT)) begin
        cclk_q <= 1'b1;
        half_q <= 4'h0;
        edges_q <= 6'(2 * `TACM_CONV_PULSES - 1);
        burst_q <= 1'b1;
      end else if (edges_q != 6'h00) begin
        if (half_q == 4'(HALF_CYC - 1)) begin
          half_q <= 4'h0;
          cclk_q <= ~cclk_q;
          edges_q <= edges_q - 6'h01;
        end else begin
          half_q <= half_q + 4'h1;
        end
      end
    end
  end

  // Start pin synchroniser with edge stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_s1_q <= 1'b0;
      st_s2_q <= 1'b0;
      st_s3_q <= 1'b0;
    end else begin
      st_s1_q <= start_pin;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
    end
  end

  assign start = (st_s2_q & ~st_s3_q) | start_sw_q;
  assign cnt_n = cnt_q + CW'(1);

  // Integration counter: low stage starts at zero, upper four take the
  // loaded length it ends when the top bit falls, so a
  // length of 8000h runs 2^19 periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
      first_q <= 1'b0;
      cnt_q <= '0;
    end else if (start) begin
      run_q <= 1'b1;
      first_q <= 1'b1;
      cnt_q <= {len_hi_q, len_lo_q, {`TACM_STAGE_W{1'b0}}};
    end else if (run_q && tick) begin
      first_q <= 1'b0;
      cnt_q <= cnt_n;
      if (cnt_q[CW-1] && !cnt_n[CW-1]) begin
        run_q <= 1'b0;
      end
    end
  end

  // Operands for the current step
  assign xbus = bus_of(op_q[pair_ch(step_q, 1'b0)]);
  assign ybus = bus_of(op_q[pair_ch(step_q, 1'b1)]);
  assign prod = xbus * ybus;

  // Sequencer: a new set is latched only at a period end, and the six
  // steps take six cycles, far inside one period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= tacm_pkg::ST_IDLE;
      step_q <= 3'h0;
      for (int i = 0; i < NCH; i++) begin
        op_q[i] <= '0;
      end
    end else begin
      case (st_q)
        tacm_pkg::ST_IDLE: begin
          if (run_q && tick && !start) begin
            for (int i = 0; i < NCH; i++) begin
              op_q[i] <= word[i];
            end
            step_q <= 3'h0;
            st_q <= tacm_pkg::ST_MAC;
          end
        end
        tacm_pkg::ST_MAC: begin
          step_q <= step_q + 3'h1;
          if (step_q == 3'(`TACM_NPROD - 1)) begin
            st_q <= tacm_pkg::ST_IDLE;
          end
        end
        default: st_q <= tacm_pkg::ST_IDLE;
      endcase
    end
  end

  // Accumulators: zero in the first period, then each step adds its
  // sign-extended product, four LSBs dropped, at its own location
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `TACM_NPROD; i++) begin
        acc_q[i] <= '0;
      end
    end else if (first_q || start) begin
      for (int i = 0; i < `TACM_NPROD; i++) begin
        acc_q[i] <= '0;
      end
    end else if (st_q == tacm_pkg::ST_MAC) begin
      acc_q[step_q] <= acc_q[step_q] + `TACM_ACC_W'(prod >>> `TACM_PROD_DROP);
    end
  end

  assign busy = run_q | (st_q == tacm_pkg::ST_MAC);

  // Readout byte: all ones while busy, else the selected sum byte on the
  // next edge while read enable is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= 8'h00;
      int_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      int_q <= busy;
      ack_q <= ctrl_q.req;
      if (busy) begin
        out_q <= 8'hFF;
      end else if (ctrl_q.rden) begin
        if (rsel_q.prod < 3'(`TACM_NPROD) && rsel_q.byte_sel < 3'(`TACM_NPROD)) begin
          out_q <= acc_q[rsel_q.prod][rsel_q.byte_sel * 8 +: 8];
        end else begin
          out_q <= 8'h00;
        end
      end
    end
  end

  // Outputs, all from flops
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign sample_pulse = sp_q;
  assign conv_clk = cclk_q;
  assign result_byte = out_q;
  assign ref_atten = ref_q;
  assign test_atten = test_q;
  assign integrating = int_q;
  assign host_ack = ack_q;

endmodule

//--- tacm_props.sv
// Concurrent checks on the correlator top ports
`timescale 1ns/1ps
module tacm_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins and results
  input wire logic start_pin,
  input wire logic sample_pulse,
  input wire logic conv_clk,
  input wire logic [7:0] result_byte,
  input wire logic [4:0] ref_atten,
  input wire logic [4:0] test_atten,
  input wire logic integrating,
  input wire logic host_ack
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take; // Address phase accepted at this edge
  logic dp_wr_q; // Write data phase in progress
  logic [7:0] dp_addr_q; // Offset of that data phase
  logic [5:0] rise_cnt_q; // Converter clock rises since the sample pulse
  logic conv_q; // Last converter clock level
  assign take = hsel && hready && htrans[1];
  // Data phase follows only when the bus is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (hready) begin
      dp_wr_q <= take && hwrite;
      dp_addr_q <= haddr[7:0];
    end
  end
  // Count rises; cleared while the sample pulse is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_cnt_q <= 6'h00;
      conv_q <= 1'b0;
    end else begin
      conv_q <= conv_clk;
      if (sample_pulse) begin
        rise_cnt_q <= 6'h00;
      end else if (conv_clk && !conv_q) begin
        rise_cnt_q <= rise_cnt_q + 6'h01;
      end
    end
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  // Request lands at the data phase edge, acknowledge flop follows one edge later
  a_ack_follows: assert property (dp_wr_q && dp_addr_q == 8'h00 |-> ##2 host_ack == $past(hwdata[3], 2))
    else $error("acknowledge differs from request");
  a_busy_ones: assert property (integrating && $past(integrating) |-> result_byte == 8'hFF)
    else $error("result not all ones while busy");
  a_conv_rise: assert property ($fell(sample_pulse) |-> ##[1:12] $rose(conv_clk))
    else $error("converter clock late");
  a_burst_count: assert property ($rose(sample_pulse) |-> rise_cnt_q == 6'd17)
    else $error("converter burst count wrong");
  a_atten_loaded: assert property ($changed({ref_atten, test_atten}) |->
    $past(dp_wr_q && dp_addr_q == 8'h10 && hwdata[14:13] != 2'b00))
    else $error("attenuator changed without load");
  a_start_runs: assert property ($rose(start_pin) |-> ##[1:8] integrating)
    else $error("start pin ignored");
endmodule

//--- tacm_adc_model.sv
// Three serial sampling converters answering the converter clock
`timescale 1ns/1ps
module tacm_adc_model #(
  parameter logic [15:0] W_REF = 16'h0000,
  parameter logic [15:0] W_TEST = 16'h0000,
  parameter logic [15:0] W_QUAD = 16'h0000
) (
  // Timing from the correlator
  input wire logic sample_pulse,
  input wire logic conv_clk,
  // Serial outputs, 0 ref, 1 test, 2 quad
  output logic [2:0] adc_dclk,
  output logic [2:0] adc_data
);
  logic [15:0] w [3]; // Fixed word per channel
  // Burst starts after the first converter clock rise, clock idles low between frames
  initial begin
    w = '{W_REF, W_TEST, W_QUAD};
    adc_dclk = 3'h0;
    adc_data = 3'h0;
    forever begin
      @(negedge sample_pulse);
      @(posedge conv_clk);
      // Step off the system clock edge so pin changes never race the sampling flops
      #1;
      for (int p = 0; p < 17; p++) begin
        if (p > 0) begin
          for (int c = 0; c < 3; c++) adc_data[c] = w[c][16 - p];
        end
        #8 adc_dclk = 3'h7;
        #32 adc_dclk = 3'h0;
        #24;
      end
      adc_data = ~adc_data; // Released line must not keep the last bit
    end
  end
endmodule

//--- tb.sv
// Testbench: bus, converters, integration and readout
`timescale 1ns/1ps
module tb;
  localparam int PF = 400; // Short fast period, still fits burst and MAC
  localparam int PS = 800; // Short slow period
  localparam logic [15:0] W_R = 16'h1235;
  localparam logic [15:0] W_T = 16'hF00B;
  localparam logic [15:0] W_Q = 16'h0407;
  // Driven inputs
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic start_pin = 1'b0;
  // Design outputs
  logic [31:0] hrdata;
  logic hreadyout, hresp, sample_pulse, conv_clk, integrating, host_ack;
  logic [7:0] result_byte;
  logic [4:0] ref_atten, test_atten;
  logic [2:0] adc_dclk, adc_data;
  logic [31:0] rd; // Last read data
  int error_cnt = 0;
  int cmp_count = 0;
  always #2 hclk = ~hclk;
  tacm_core #(.PER_FAST(PF), .PER_SLOW(PS), .NCH(3)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .adc_dclk(adc_dclk), .adc_data(adc_data),
    .sample_pulse(sample_pulse), .conv_clk(conv_clk), .start_pin(start_pin), .result_byte(result_byte),
    .ref_atten(ref_atten), .test_atten(test_atten), .integrating(integrating), .host_ack(host_ack));
  tacm_adc_model #(.W_REF(W_R), .W_TEST(W_T), .W_QUAD(W_Q)) u_adc (.sample_pulse(sample_pulse),
    .conv_clk(conv_clk), .adc_dclk(adc_dclk), .adc_data(adc_data));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang(input string s);
    error_cnt++;
    $display("unexpected at %0t: %s timed out", $time, s);
    report_and_stop();
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  // Bounded wait for the slave's ready
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) hang("bus");
      @(posedge hclk);
    end
  endtask
  // One single word transfer, address phase then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wait_int(input logic lvl, output int n);
    n = 0;
    while (integrating !== lvl) begin
      @(posedge hclk);
      n++;
      if (n > 30000) hang("integration");
    end
  endtask
  // Operand the design should keep: two's complement, two low bits dropped
  function automatic longint op(input logic [15:0] w);
    return longint'($signed(w[15:2]));
  endfunction
  task automatic t_reset_refuse();
    bus(8'h18, 1'b0, 32'h0);
    chk(48'(rd), 48'h0, "status after reset");
    bus(8'h1C, 1'b0, 32'h0);
    chk(48'(rd), 48'h0, "unmapped read");
    bus(8'h10, 1'b1, 32'h0000_7F00);
    @(posedge hclk);
    chk(48'({ref_atten, test_atten}), 48'h0, "load without request");
    $display("test reset_refuse done");
  endtask
  task automatic t_atten();
    bus(8'h00, 1'b1, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    chk(48'(host_ack), 48'h1, "acknowledge");
    bus(8'h10, 1'b1, 32'h0000_3500);
    bus(8'h10, 1'b1, 32'h0000_4A00);
    bus(8'h10, 1'b1, 32'h0000_1F00); // No load bit: both must hold
    @(posedge hclk);
    chk(48'({ref_atten, test_atten}), 48'h2AA, "attenuators");
    bus(8'h10, 1'b0, 32'h0);
    chk(48'(rd), 48'h0A15, "attenuator readback");
    $display("test atten done");
  endtask
  task automatic t_integrate();
    logic [15:0] wv [3];
    int pa [6];
    int pb [6];
    int n;
    logic [47:0] ex;
    wv = '{W_R, W_T, W_Q};
    pa = '{1, 2, 0, 1, 1, 2};
    pb = '{1, 2, 0, 2, 0, 0};
    bus(8'h04, 1'b1, 32'h0000_FF00);
    bus(8'h08, 1'b1, 32'h0000_FF00);
    bus(8'h00, 1'b1, 32'h0000_000C);
    start_pin <= 1'b1;
    wait_int(1'b1, n);
    start_pin <= 1'b0;
    bus(8'h14, 1'b0, 32'h0);
    chk(48'(rd[7:0]), 48'hFF, "read while busy");
    wait_int(1'b0, n);
    chk(48'(n > 15 * PF - 10 && n < 16 * PF + 20), 48'h1, "fast length");
    // Sixteen sample sets, the first ignored
    for (int k = 0; k < 6; k++) begin
      ex = 48'(15 * op(wv[pa[k]]) * op(wv[pb[k]]));
      for (int b = 0; b < 6; b++) begin
        bus(8'h0C, 1'b1, 32'(b * 16 + k));
        @(posedge hclk);
        bus(8'h14, 1'b0, 32'h0);
        chk(48'(rd[7:0]), 48'(ex[8 * b +: 8]), "sum byte");
        chk(48'(result_byte), 48'(ex[8 * b +: 8]), "result pins");
      end
    end
    $display("test integrate done");
  endtask
  task automatic t_slow();
    int n;
    bus(8'h00, 1'b1, 32'h0000_000F);
    wait_int(1'b1, n);
    wait_int(1'b0, n);
    chk(48'(n > 15 * PS - 10 && n < 16 * PS + 20), 48'h1, "slow length kept");
    $display("test slow done");
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_refuse();
    t_atten();
    t_integrate();
    t_slow();
    report_and_stop();
  end
endmodule
bind tacm_core tacm_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .start_pin(start_pin), .sample_pulse(sample_pulse), .conv_clk(conv_clk), .result_byte(result_byte),
  .ref_atten(ref_atten), .test_atten(test_atten), .integrating(integrating), .host_ack(host_ack));
